// file: verilog/irqc_pkg.sv
package irqc_pkg;

    // ------------------------------------------------------------
    // Source counts
    // ------------------------------------------------------------
    localparam int N_LEVEL = 16;
    localparam int N_EDGE = 8;
    localparam int N_SRC = 24;
    localparam int ID_W = 5;
    localparam int ADDR_W = 12;

    // Byte lanes of the 24-bit mask, priority and flag words
    localparam int BYTE_W = 8;
    localparam int LANE0_LSB = 0;
    localparam int LANE1_LSB = 8;
    localparam int LANE2_LSB = 16;

    // ------------------------------------------------------------
    // Device register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_MASK0 = 12'h640;
    localparam logic [11:0] ADDR_MASK1 = 12'h641;
    localparam logic [11:0] ADDR_MASK2 = 12'h642;
    localparam logic [11:0] ADDR_GCTL = 12'h643;
    localparam logic [11:0] ADDR_PRIO0 = 12'h644;
    localparam logic [11:0] ADDR_PRIO1 = 12'h645;
    localparam logic [11:0] ADDR_PRIO2 = 12'h646;
    localparam logic [11:0] ADDR_SRC0 = 12'h648;
    localparam logic [11:0] ADDR_SRC1 = 12'h649;
    localparam logic [11:0] ADDR_SRC2 = 12'h64a;

    // Implemented bits of each byte; reserved bits read zero
    localparam logic [7:0] LVL_LO_VALID = 8'hd7;
    localparam logic [7:0] LVL_HI_VALID = 8'hf0;
    localparam logic [7:0] EDGE_VALID = 8'hfc;
    localparam int STIMER_EDGE_BIT = 4;
    localparam int GEN_EN_BIT = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Core-end AHB-Lite register map
    // ------------------------------------------------------------
    localparam logic [7:0] HOFF_CMD = 8'h00;
    localparam logic [7:0] HOFF_STATUS = 8'h04;
    localparam logic [7:0] HOFF_INT_STATUS = 8'h08;
    localparam logic [7:0] HOFF_INT_MASK = 8'h0c;
    localparam int CMD_DATA_LSB = 12;
    localparam int CMD_WR_BIT = 24;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_RDATA_LSB = 8;
    localparam int ST_IRQ_BIT = 16;
    localparam int ST_HIGH_BIT = 17;
    localparam int ST_ID_LSB = 18;
    localparam int INT_W = 2;
    localparam int INT_DONE_BIT = 0;
    localparam int INT_CORE_BIT = 1;
    localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

endpackage

// file: verilog/irqc_if.sv
`timescale 1ns/1ps
interface irqc_if;
    logic reg_req;
    logic reg_wr;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_ack;
    logic [7:0] reg_rdata;
    logic core_irq;
    logic core_irq_high;
    logic [4:0] core_src_id;

    modport dev (
        input reg_req,
        input reg_wr,
        input reg_addr,
        input reg_wdata,
        output reg_ack,
        output reg_rdata,
        output core_irq,
        output core_irq_high,
        output core_src_id
    );

    modport core (
        output reg_req,
        output reg_wr,
        output reg_addr,
        output reg_wdata,
        input reg_ack,
        input reg_rdata,
        input core_irq,
        input core_irq_high,
        input core_src_id
    );
endinterface

// file: verilog/irqc_device.sv
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module irqc_device (
    input wire logic clk,
    input wire logic rst_n,
    irqc_if.dev bus,
    input wire logic [15:0] level_src,
    input wire logic [7:0] edge_src,
    input wire logic stimer_local_mask,
    output logic [23:0] src_flags
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Whole state in one word so reset and update stay in one place
    typedef struct packed {
        logic [23:0] mask;
        logic gen_en;
        logic [23:0] prio;
        logic [7:0] edge_flag;
        logic [7:0] edge_prev;
        logic [23:0] flags;
        logic ack;
        logic [7:0] rdata;
        logic irq;
        logic high;
        logic [4:0] id;
    } irqc_dev_state_t;

    irqc_dev_state_t st_reg;
    irqc_dev_state_t st_next;

    localparam logic [15:0] LEVEL_VALID = {irqc_pkg::LVL_HI_VALID, irqc_pkg::LVL_LO_VALID};

    // Byte lanes of the 24-bit mask, priority and flag words
    localparam int BW = irqc_pkg::BYTE_W;
    localparam int LANE0 = irqc_pkg::LANE0_LSB;
    localparam int LANE1 = irqc_pkg::LANE1_LSB;
    localparam int LANE2 = irqc_pkg::LANE2_LSB;

    logic [7:0] edge_rise;
    logic [7:0] edge_clr;
    logic [23:0] pending;
    logic [23:0] hi_pending;
    logic found_hi;
    logic found_any;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.ack = 1'b0;
        edge_clr = '0;
        found_hi = 1'b0;
        found_any = 1'b0;

        // Only rising edges set a flag; a held-high source does not refire
        edge_rise = edge_src & ~st_reg.edge_prev;
        if (!stimer_local_mask) begin
            edge_rise[irqc_pkg::STIMER_EDGE_BIT] = 1'b0;
        end
        st_next.edge_prev = edge_src;

        // One access per request, answered at the next edge; holes and read-only bytes are still answered
        if (bus.reg_req) begin
            st_next.ack = 1'b1;
            if (bus.reg_wr) begin
                // Reserved bits are never stored, so they read back as zero
                case (bus.reg_addr)
                    irqc_pkg::ADDR_MASK0: begin
                        st_next.mask[LANE0 +: BW] = bus.reg_wdata & irqc_pkg::LVL_LO_VALID;
                    end
                    irqc_pkg::ADDR_MASK1: begin
                        st_next.mask[LANE1 +: BW] = bus.reg_wdata & irqc_pkg::LVL_HI_VALID;
                    end
                    irqc_pkg::ADDR_MASK2: begin
                        st_next.mask[LANE2 +: BW] = bus.reg_wdata & irqc_pkg::EDGE_VALID;
                    end
                    irqc_pkg::ADDR_GCTL: begin
                        // Bits one to seven are not stored and read zero
                        st_next.gen_en = bus.reg_wdata[irqc_pkg::GEN_EN_BIT];
                    end
                    irqc_pkg::ADDR_PRIO0: begin
                        st_next.prio[LANE0 +: BW] = bus.reg_wdata & irqc_pkg::LVL_LO_VALID;
                    end
                    irqc_pkg::ADDR_PRIO1: begin
                        st_next.prio[LANE1 +: BW] = bus.reg_wdata & irqc_pkg::LVL_HI_VALID;
                    end
                    irqc_pkg::ADDR_PRIO2: begin
                        st_next.prio[LANE2 +: BW] = bus.reg_wdata & irqc_pkg::EDGE_VALID;
                    end
                    irqc_pkg::ADDR_SRC2: begin
                        edge_clr = bus.reg_wdata & irqc_pkg::EDGE_VALID;
                    end
                    default: begin
                        // Level flag bytes and holes ignore writes
                    end
                endcase
            end else begin
                // Reads answer from the registered copy; rdata holds until the next read
                case (bus.reg_addr)
                    irqc_pkg::ADDR_MASK0: begin
                        st_next.rdata = st_reg.mask[LANE0 +: BW];
                    end
                    irqc_pkg::ADDR_MASK1: begin
                        st_next.rdata = st_reg.mask[LANE1 +: BW];
                    end
                    irqc_pkg::ADDR_MASK2: begin
                        st_next.rdata = st_reg.mask[LANE2 +: BW];
                    end
                    irqc_pkg::ADDR_GCTL: begin
                        st_next.rdata = irqc_pkg::RESET_BYTE;
                        st_next.rdata[irqc_pkg::GEN_EN_BIT] = st_reg.gen_en;
                    end
                    irqc_pkg::ADDR_PRIO0: begin
                        st_next.rdata = st_reg.prio[LANE0 +: BW];
                    end
                    irqc_pkg::ADDR_PRIO1: begin
                        st_next.rdata = st_reg.prio[LANE1 +: BW];
                    end
                    irqc_pkg::ADDR_PRIO2: begin
                        st_next.rdata = st_reg.prio[LANE2 +: BW];
                    end
                    irqc_pkg::ADDR_SRC0: begin
                        st_next.rdata = st_reg.flags[LANE0 +: BW];
                    end
                    irqc_pkg::ADDR_SRC1: begin
                        st_next.rdata = st_reg.flags[LANE1 +: BW];
                    end
                    irqc_pkg::ADDR_SRC2: begin
                        st_next.rdata = st_reg.flags[LANE2 +: BW];
                    end
                    default: begin
                        st_next.rdata = irqc_pkg::RESET_BYTE;
                    end
                endcase
            end
        end

        // A new edge in the clearing cycle survives the clear
        st_next.edge_flag = ((st_reg.edge_flag & ~edge_clr) | edge_rise) & irqc_pkg::EDGE_VALID;

        // Level flags mirror the source; only the module can drop them
        st_next.flags = {st_next.edge_flag, level_src & LEVEL_VALID};

        // The next-state copy is used, so a mask or enable write acts at its answer edge
        pending = st_next.flags & st_next.mask & {irqc_pkg::N_SRC{st_next.gen_en}};
        hi_pending = pending & st_next.prio;
        st_next.irq = |pending;
        st_next.high = |hi_pending;

        // Lowest-numbered high source wins, else lowest-numbered low one
        // Fixed order: a busy low-numbered source can starve others of the same level
        st_next.id = '0;
        for (int i = 0; i < irqc_pkg::N_SRC; i++) begin
            if (!found_hi && hi_pending[i]) begin
                st_next.id = 5'(i);
                found_hi = 1'b1;
            end
        end
        if (!found_hi) begin
            for (int i = 0; i < irqc_pkg::N_SRC; i++) begin
                if (!found_any && pending[i]) begin
                    st_next.id = 5'(i);
                    found_any = 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output is a flop copy; nothing combinational leaves the block
    assign bus.reg_ack = st_reg.ack;
    assign bus.reg_rdata = st_reg.rdata;
    assign bus.core_irq = st_reg.irq;
    assign bus.core_irq_high = st_reg.high;
    assign bus.core_src_id = st_reg.id;
    assign src_flags = st_reg.flags;

endmodule

// file: verilog/irqc_core_end.sv
`timescale 1ns/1ps
module irqc_core_end (
    input wire logic clk,
    input wire logic rst_n,
    irqc_if.core bus,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic dp_write;
        logic [7:0] dp_off;
        logic busy;
        logic req;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
        logic [7:0] last_rdata;
        logic [1:0] int_status;
        logic [1:0] int_mask;
        logic prev_core_irq;
        logic [31:0] hrdata;
        logic irq;
        logic rdy;
    } irqc_core_state_t;

    irqc_core_state_t st_reg;
    irqc_core_state_t st_next;

    logic addr_phase;
    logic [1:0] int_clr;
    logic [1:0] int_evt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.req = 1'b0;
        st_next.dp_write = 1'b0;
        st_next.rdy = 1'b1;
        int_clr = '0;
        int_evt = '0;
        addr_phase = hsel && hready && (htrans & irqc_pkg::HTRANS_NONSEQ_BIT) != 2'h0;

        // Write data phase; hsize is always a word here
        if (st_reg.dp_write) begin
            case (st_reg.dp_off)
                irqc_pkg::HOFF_CMD: begin
                    // Orders arriving while busy are dropped; poll busy first
                    if (!st_reg.busy) begin
                        st_next.busy = 1'b1;
                        st_next.req = 1'b1;
                        st_next.addr = hwdata[irqc_pkg::ADDR_W-1:0];
                        st_next.wdata = hwdata[irqc_pkg::CMD_DATA_LSB +: irqc_pkg::BYTE_W];
                        st_next.wr = hwdata[irqc_pkg::CMD_WR_BIT];
                    end
                end
                irqc_pkg::HOFF_INT_STATUS: int_clr = hwdata[irqc_pkg::INT_W-1:0];
                irqc_pkg::HOFF_INT_MASK: st_next.int_mask = hwdata[irqc_pkg::INT_W-1:0];
                default: begin
                end
            endcase
        end

        if (bus.reg_ack) begin
            st_next.busy = 1'b0;
            if (!st_reg.wr) begin
                st_next.last_rdata = bus.reg_rdata;
            end
        end

        // Core sees a new request; responding is left to software
        int_evt[irqc_pkg::INT_DONE_BIT] = bus.reg_ack;
        int_evt[irqc_pkg::INT_CORE_BIT] = bus.core_irq && !st_reg.prev_core_irq;
        st_next.prev_core_irq = bus.core_irq;
        st_next.int_status = (st_reg.int_status & ~int_clr) | int_evt;
        st_next.irq = |(st_next.int_status & st_next.int_mask);

        // Read data is captured at the address phase, so the bus never waits
        if (addr_phase) begin
            st_next.dp_write = hwrite;
            st_next.dp_off = haddr[7:0];
            st_next.hrdata = '0;
            if (!hwrite) begin
                case (haddr[7:0])
                    irqc_pkg::HOFF_CMD: begin
                        st_next.hrdata = 32'({st_reg.wr, 4'h0, st_reg.wdata, st_reg.addr});
                    end
                    irqc_pkg::HOFF_STATUS: begin
                        st_next.hrdata[irqc_pkg::ST_BUSY_BIT] = st_reg.busy;
                        st_next.hrdata[irqc_pkg::ST_RDATA_LSB +: irqc_pkg::BYTE_W] = st_reg.last_rdata;
                        st_next.hrdata[irqc_pkg::ST_IRQ_BIT] = bus.core_irq;
                        st_next.hrdata[irqc_pkg::ST_HIGH_BIT] = bus.core_irq_high;
                        st_next.hrdata[irqc_pkg::ST_ID_LSB +: irqc_pkg::ID_W] = bus.core_src_id;
                    end
                    irqc_pkg::HOFF_INT_STATUS: st_next.hrdata[irqc_pkg::INT_W-1:0] = st_reg.int_status;
                    irqc_pkg::HOFF_INT_MASK: st_next.hrdata[irqc_pkg::INT_W-1:0] = st_reg.int_mask;
                    default: st_next.hrdata = '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus.reg_req = st_reg.req;
    assign bus.reg_wr = st_reg.wr;
    assign bus.reg_addr = st_reg.addr;
    assign bus.reg_wdata = st_reg.wdata;
    assign hreadyout = st_reg.rdy;
    assign hresp = 1'b0;
    assign hrdata = st_reg.hrdata;
    assign irq = st_reg.irq;

endmodule

// file: sim/irqc_assertions.sv
`timescale 1ns/1ps
module irqc_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_req,
    input wire logic reg_wr,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_ack,
    input wire logic [7:0] reg_rdata,
    input wire logic core_irq,
    input wire logic core_irq_high,
    input wire logic [4:0] core_src_id
);
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    localparam logic [23:0] MAPPED = 24'hfcf0d7;
    logic gen_q;
    logic rd_q;
    logic [11:0] addr_q;

    // Shadow of the global enable, taken on the same edge the device takes the write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gen_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 12'h000;
        end else begin
            rd_q <= reg_req && !reg_wr;
            addr_q <= reg_addr;
            if (reg_req && reg_wr && reg_addr == irqc_pkg::ADDR_GCTL) begin
                gen_q <= reg_wdata[irqc_pkg::GEN_EN_BIT];
            end
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_ACK_ONE: assert property (reg_req |=> reg_ack)
        else $error("access not acknowledged one cycle later");
    AST_ACK_CAUSE: assert property (reg_ack |-> $past(reg_req))
        else $error("acknowledge without a request");
    AST_GEN_OFF: assert property (reg_req && reg_wr && reg_addr == irqc_pkg::ADDR_GCTL && !reg_wdata[0] |=> !core_irq)
        else $error("core request survives global disable");
    AST_GEN_GATE: assert property (core_irq |-> gen_q)
        else $error("core request while globally disabled");
    AST_IDLE_ID: assert property (gen_q && !core_irq |-> core_src_id == 5'h00 && !core_irq_high)
        else $error("source id or priority shown with nothing pending");
    AST_ID_MAPPED: assert property (core_irq |-> core_src_id < 5'd24 && MAPPED[core_src_id])
        else $error("presented source id is not a mapped source");
    AST_RDATA_HOLD: assert property (!rd_q |-> $stable(reg_rdata))
        else $error("read data changed outside a read answer");
    AST_GCTL_RSVD: assert property (rd_q && addr_q == irqc_pkg::ADDR_GCTL |-> reg_rdata[7:1] == 7'h00)
        else $error("reserved global control bits read nonzero");
    AST_MASK0_RSVD: assert property (rd_q && addr_q == irqc_pkg::ADDR_MASK0 |-> (reg_rdata & 8'h28) == 8'h00)
        else $error("reserved low level mask bits read nonzero");
    AST_MASK1_RSVD: assert property (rd_q && addr_q == irqc_pkg::ADDR_MASK1 |-> reg_rdata[3:0] == 4'h0)
        else $error("reserved high level mask bits read nonzero");
    AST_MASK2_RSVD: assert property (rd_q && addr_q == irqc_pkg::ADDR_MASK2 |-> reg_rdata[1:0] == 2'h0)
        else $error("reserved edge mask bits read nonzero");
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_n, hsel, hwrite, hreadyout, hresp, irq, stmask;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] level_src;
    logic [7:0] edge_src;
    logic [23:0] src_flags;
    logic [7:0] vmask [0:6] = '{8'hd7, 8'hf0, 8'hfc, 8'h01, 8'hd7, 8'hf0, 8'hfc};
    int num_errors = 0;
    int num_checks = 0;

    irqc_if i_irqc_if();
    irqc_device i_irqc_device (.clk(clk), .rst_n(rst_n), .bus(i_irqc_if), .level_src(level_src),
        .edge_src(edge_src), .stimer_local_mask(stmask), .src_flags(src_flags));
    irqc_core_end i_irqc_core_end (.clk(clk), .rst_n(rst_n), .bus(i_irqc_if), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
    irqc_assertions i_irqc_assertions (.clk(clk), .rst_n(rst_n), .reg_req(i_irqc_if.reg_req),
        .reg_wr(i_irqc_if.reg_wr), .reg_addr(i_irqc_if.reg_addr), .reg_wdata(i_irqc_if.reg_wdata),
        .reg_ack(i_irqc_if.reg_ack), .reg_rdata(i_irqc_if.reg_rdata), .core_irq(i_irqc_if.core_irq),
        .core_irq_high(i_irqc_if.core_irq_high), .core_src_id(i_irqc_if.core_src_id));

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= irqc_pkg::HTRANS_NONSEQ_BIT;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Completion is taken from the done flag, not busy; the flag stays set until the task clears it with a write of one
    task automatic dev_acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        ahb(1'b1, 32'h0, {7'h00, w, 4'h0, d, a});
        rd = 32'h0;
        while (rd[0] !== 1'b1) ahb(1'b0, 32'h8, 32'h0);
        ahb(1'b1, 32'h8, 32'h1);
    endtask

    task automatic dev_chk(input logic [11:0] a, input logic [7:0] e);
        dev_acc(1'b0, a, 8'h00);
        ahb(1'b0, 32'h4, 32'h0);
        check({24'h0, rd[15:8]}, {24'h0, e});
    endtask

    // Status is sampled at the address phase, so a source change needs one edge to reach the device outputs first
    task automatic st_chk(input logic q, input logic h, input logic [4:0] id);
        @(posedge clk);
        ahb(1'b0, 32'h4, 32'h0);
        check({25'h0, rd[22:16]}, {25'h0, id, h, q});
    endtask

    task automatic pulse(input logic [7:0] v);
        edge_src <= v;
        repeat (2) @(posedge clk);
        edge_src <= 8'h00;
        @(posedge clk);
    endtask

    task automatic end_of_test();
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // The whole sequence needs some five hundred cycles; sixty times that means a hang
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        end_of_test();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        int i;
        rst_n = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        level_src = 16'h0000;
        edge_src = 8'h00;
        stmask = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        for (i = 0; i < 11; i++) dev_chk(12'h640 + 12'(i), 8'h00);
        for (i = 0; i < 7; i++) dev_acc(1'b1, 12'h640 + 12'(i), 8'hff);
        for (i = 0; i < 7; i++) dev_chk(12'h640 + 12'(i), vmask[i]);
        dev_acc(1'b1, 12'h648, 8'hff);
        dev_chk(12'h648, 8'h00);
        for (i = 0; i < 7; i++) dev_acc(1'b1, 12'h640 + 12'(i), 8'h00);
        level_src <= 16'hffff;
        dev_chk(12'h648, 8'hd7);
        dev_chk(12'h649, 8'hf0);
        check({8'h0, src_flags}, 32'h0000f0d7);
        st_chk(1'b0, 1'b0, 5'd0);
        level_src <= 16'h0000;
        dev_chk(12'h648, 8'h00);
        pulse(8'hff);
        dev_chk(12'h64a, 8'hec);
        dev_acc(1'b1, 12'h64a, 8'hff);
        dev_chk(12'h64a, 8'h00);
        stmask <= 1'b1;
        pulse(8'h10);
        dev_chk(12'h64a, 8'h10);
        dev_acc(1'b1, 12'h64a, 8'h10);
        dev_acc(1'b1, 12'h642, 8'h04);
        ahb(1'b1, 32'hc, 32'h2);
        pulse(8'h04);
        st_chk(1'b0, 1'b0, 5'd0);
        dev_acc(1'b1, 12'h643, 8'h01);
        st_chk(1'b1, 1'b0, 5'd18);
        check({31'h0, irq}, 32'h1);
        dev_acc(1'b1, 12'h64a, 8'h04);
        st_chk(1'b0, 1'b0, 5'd0);
        ahb(1'b1, 32'h8, 32'h2);
        ahb(1'b0, 32'h8, 32'h0);
        check({31'h0, irq}, 32'h0);
        dev_acc(1'b1, 12'h640, 8'h01);
        dev_acc(1'b1, 12'h641, 8'h80);
        level_src <= 16'h8001;
        st_chk(1'b1, 1'b0, 5'd0);
        dev_acc(1'b1, 12'h645, 8'h80);
        st_chk(1'b1, 1'b1, 5'd15);
        level_src <= 16'h8000;
        dev_chk(12'h648, 8'h00);
        dev_acc(1'b1, 12'h643, 8'h00);
        st_chk(1'b0, 1'b0, 5'd0);
        end_of_test();
    end
endmodule
